/* design/lqa_limit_store.sv */
`timescale 1ns/1ps
`default_nettype none
module lqa_limit_store #(
  parameter int SLOTS = lqa_pkg::NUM_SLOTS,
  parameter int IDX_W = lqa_pkg::SLOT_IDX_W,
  parameter logic [7:0] SLOT_RESET = lqa_pkg::LIMIT_SLOT_RESET
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic commit,
  input wire logic [IDX_W-1:0] slot_idx,
  input wire logic [7:0] store_data,
  output logic [SLOTS*8-1:0] limit_bytes
);
  import lqa_pkg::*;

  typedef struct packed {
    logic [SLOTS-1:0][7:0] slot;
  } lqa_store_state_t;

  lqa_store_state_t st;
  lqa_store_state_t next_st;
  logic [SLOTS-1:0][7:0] entry_next;

  // ****************************************
  // Per-entry write decode
  // ****************************************
  for (genvar gi = 0; gi < SLOTS; gi++) begin : g_entry
    // Only the addressed entry loads; the rest hold
    assign entry_next[gi] = (commit && slot_idx == IDX_W'(gi)) ? store_data : st.slot[gi];
  end

  // Next state copy
  always_comb begin
    next_st = st;
    next_st.slot = entry_next;
  end

  // State register
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{slot: {SLOTS{SLOT_RESET}}};
    end else begin
      st <= next_st;
    end
  end

  assign limit_bytes = st.slot;

  // ****************************************
  // Checks
  // ****************************************
  a_entry_load: assert property (@(posedge clock) disable iff (!rst_n)
    commit |=> st.slot[$past(slot_idx)] == $past(store_data))
    else $error("addressed limit entry did not load");

endmodule
`default_nettype wire

/* design/lqa_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lqa_top #(
  parameter int ADDR_W = lqa_pkg::APB_ADDR_W,
  parameter int METRICS = lqa_pkg::NUM_METRICS,
  parameter int LIVE_W = lqa_pkg::LIVE_W
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [METRICS*LIVE_W-1:0] live_params,
  output logic [2*METRICS*8-1:0] limit_table,
  output logic power_down
);
  import lqa_pkg::*;

  // ****************************************
  // Addresses
  // ****************************************
  localparam logic [ADDR_W-1:0] DATA_ADDR = ADDR_W'(LQ_DATA_IDX * IDX_TO_BYTE);
  localparam logic [ADDR_W-1:0] PWR_ADDR = ADDR_W'(POWER_CTRL_IDX * IDX_TO_BYTE);
  localparam int SLOTS = 2 * METRICS;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    lqa_phase_t phase;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic live_sample;
    logic [2:0] metric_select;
    logic limit_high_low_select;
    logic [7:0] limit_byte;
    logic [7:0] sample_byte;
    logic power_down;
  } lqa_top_state_t;

  lqa_top_state_t st;
  lqa_top_state_t next_st;

  logic setup_cyc;
  logic done_cyc;
  logic wr_done;
  logic hit_data;
  logic hit_pwr;
  logic ctrl_lane;
  logic new_live;
  logic new_commit;
  logic [2:0] new_metric;
  logic new_hl;
  logic [7:0] new_byte;
  logic commit_go;
  logic sample_go;
  logic [SLOT_IDX_W-1:0] commit_slot;
  logic [SLOT_IDX_W-1:0] read_slot;
  logic [7:0] read_limit;
  logic [7:0] live_byte;
  logic [31:0] read_word;

  // ****************************************
  // Helpers
  // ****************************************
  // Slot index is the select pair; codes 110 and 111 map to nothing
  function automatic logic metric_ok(input logic [2:0] m);
    metric_ok = (32'(m) < METRICS);
  endfunction

  function automatic logic [SLOT_IDX_W-1:0] slot_of(input logic [2:0] m, input logic hl);
    slot_of = {m, hl};
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  assign setup_cyc = psel & ~penable;
  assign done_cyc = psel & penable & st.pready;
  assign wr_done = done_cyc & pwrite;
  assign hit_data = (paddr == DATA_ADDR);
  assign hit_pwr = (paddr == PWR_ADDR);
  assign ctrl_lane = pstrb[LANE_CTRL];

  // Merge by byte lane; an unstrobed lane keeps what is stored
  assign new_live = ctrl_lane ? pwdata[LIVE_BIT] : st.live_sample;
  assign new_commit = ctrl_lane & pwdata[COMMIT_BIT];
  assign new_metric = ctrl_lane ? pwdata[SEL_HI:SEL_LO] : st.metric_select;
  assign new_hl = ctrl_lane ? pwdata[HL_BIT] : st.limit_high_low_select;
  assign new_byte = pstrb[LANE_LOW] ? pwdata[BYTE_HI:0] : st.limit_byte;

  // Store uses this same write's fields, and only with sampling off
  assign commit_go = wr_done & hit_data & new_commit & ~new_live
                     & ~st.power_down & metric_ok(new_metric);
  assign commit_slot = slot_of(new_metric, new_hl);
  assign sample_go = wr_done & hit_data & ctrl_lane & pwdata[LIVE_BIT];

  // ****************************************
  // Live value pick
  // ****************************************
  // Variance is wider than a byte; the high/low bit picks its half
  always_comb begin
    live_byte = '0;
    if (metric_ok(new_metric)) begin
      if (new_metric == LQA_VARIANCE && new_hl) begin
        live_byte = live_params[32'(new_metric) * LIVE_W + 8 +: 8];
      end else begin
        live_byte = live_params[32'(new_metric) * LIVE_W +: 8];
      end
    end
  end

  // Selected limit for readback
  assign read_slot = slot_of(st.metric_select, st.limit_high_low_select);
  always_comb begin
    read_limit = '0;
    if (metric_ok(st.metric_select)) begin
      read_limit = limit_table[32'(read_slot) * 8 +: 8];
    end
  end

  // ****************************************
  // Read mux
  // ****************************************
  // Reserved and strobe bits are not stored, so they read as zero
  always_comb begin
    read_word = '0;
    if (hit_data) begin
      read_word[LIVE_BIT] = st.live_sample;
      read_word[COMMIT_BIT] = 1'b0;
      read_word[SEL_HI:SEL_LO] = st.metric_select;
      read_word[HL_BIT] = st.limit_high_low_select;
      read_word[BYTE_HI:0] = st.live_sample ? st.sample_byte : read_limit;
    end else if (hit_pwr) begin
      read_word[PWR_BIT] = st.power_down;
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    case (st.phase)
      LQA_IDLE: begin
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
        if (setup_cyc) begin
          // Answer in the first access cycle, data latched at setup
          next_st.phase = LQA_ACCESS;
          next_st.pready = 1'b1;
          next_st.pslverr = ~(hit_data | hit_pwr);
          next_st.prdata = pwrite ? '0 : read_word;
        end
      end
      LQA_ACCESS: begin
        if (done_cyc || !psel) begin
          next_st.phase = LQA_IDLE;
          next_st.pready = 1'b0;
          next_st.pslverr = 1'b0;
          next_st.prdata = '0;
        end
        if (wr_done && hit_data) begin
          // Bits 15:14 are simply not stored
          next_st.live_sample = new_live;
          next_st.metric_select = new_metric;
          next_st.limit_high_low_select = new_hl;
          next_st.limit_byte = new_byte;
        end
        if (sample_go) begin
          next_st.sample_byte = live_byte;
        end
        if (wr_done && hit_pwr && pstrb[LANE_LOW]) begin
          next_st.power_down = pwdata[PWR_BIT];
        end
      end
      default: begin
        next_st.phase = LQA_IDLE;
        next_st.pready = 1'b0;
        next_st.pslverr = 1'b0;
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '{
        phase: LQA_IDLE,
        pready: 1'b0,
        pslverr: 1'b0,
        prdata: '0,
        live_sample: 1'b0,
        metric_select: 3'h0,
        limit_high_low_select: 1'b0,
        limit_byte: LIMIT_BYTE_RESET,
        sample_byte: 8'h00,
        power_down: 1'b0
      };
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Limit storage
  // ****************************************
  lqa_limit_store #(
    .SLOTS(SLOTS),
    .IDX_W(SLOT_IDX_W),
    .SLOT_RESET(LIMIT_SLOT_RESET)
  ) u_store (
    .clock(clock),
    .rst_n(rst_n),
    .commit(commit_go),
    .slot_idx(commit_slot),
    .store_data(new_byte),
    .limit_bytes(limit_table)
  );

  // Outputs straight from flops
  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign power_down = st.power_down;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_apb_answer: assert property (setup_cyc && st.phase == LQA_IDLE |=> pready ##1 !pready || !penable)
    else $error("slave did not answer in the first access cycle");

  a_reserved_zero: assert property (
    pready && !pwrite && hit_data |-> prdata[31:14] == '0)
    else $error("reserved bits of data word not zero");

  a_strobe_reads_zero: assert property (
    pready && !pwrite && hit_data |-> !prdata[COMMIT_BIT])
    else $error("commit strobe read back as one");

  a_sample_capture: assert property (
    sample_go |=> st.sample_byte == $past(live_byte) && st.live_sample)
    else $error("live value not captured on sample write");

  a_sample_frozen: assert property (
    !sample_go |=> $stable(st.sample_byte))
    else $error("sampled value changed without a new sample");

  a_sample_read: assert property (
    pready && !pwrite && hit_data && st.live_sample |-> prdata[BYTE_HI:0] == st.sample_byte)
    else $error("read with sampling on did not return sample");

  a_limit_read: assert property (
    pready && !pwrite && hit_data && !st.live_sample |-> prdata[BYTE_HI:0] == read_limit)
    else $error("read with sampling off did not return limit");

  a_commit_store: assert property (
    commit_go |=> limit_table[32'($past(commit_slot)) * 8 +: 8] == $past(new_byte))
    else $error("commit did not store this write's byte");

  a_variance_top: assert property (
    commit_go && new_metric == LQA_VARIANCE && new_hl |=> limit_table[SLOTS*8-1 -: 8] == $past(new_byte))
    else $error("variance upper byte not in last slot");

  a_no_live_commit: assert property (
    wr_done && hit_data && new_live |=> $stable(limit_table))
    else $error("limit changed by a write with sampling on");

  a_power_block: assert property (
    st.power_down |=> $stable(limit_table))
    else $error("limit changed while powered down");

  a_bad_metric: assert property (
    wr_done && hit_data && !metric_ok(new_metric) |=> $stable(limit_table))
    else $error("unused metric code stored a limit");

  c_commit: cover property (commit_go ##1 setup_cyc ##1 pready);
  c_sample: cover property (sample_go ##[1:4] (pready && !pwrite && hit_data));
  c_blocked: cover property (st.power_down && wr_done && hit_data && new_commit);
  c_slverr: cover property (pready && pslverr);

endmodule
`default_nettype wire

/* inc/lqa_pkg.sv */
package lqa_pkg;

  // ****************************************
  // Bus and map
  // ****************************************
  localparam int APB_ADDR_W = 10;
  localparam int LQ_DATA_IDX = 32'h1E;
  localparam int POWER_CTRL_IDX = 32'h0;
  localparam int IDX_TO_BYTE = 4;

  // ****************************************
  // Field layout of the data/access word
  // ****************************************
  localparam int LIVE_BIT = 13;
  localparam int COMMIT_BIT = 12;
  localparam int SEL_HI = 11;
  localparam int SEL_LO = 9;
  localparam int HL_BIT = 8;
  localparam int BYTE_HI = 7;
  localparam int PWR_BIT = 0;
  localparam int LANE_LOW = 0;
  localparam int LANE_CTRL = 1;

  // ****************************************
  // Reset values and sizes
  // ****************************************
  localparam logic [7:0] LIMIT_BYTE_RESET = 8'h80;
  localparam logic [7:0] LIMIT_SLOT_RESET = 8'h00;
  localparam int NUM_METRICS = 6;
  localparam int NUM_SLOTS = 2 * NUM_METRICS;
  localparam int SLOT_IDX_W = 4;
  localparam int LIVE_W = 16;

  // Metric codes of the select field
  typedef enum logic [2:0] {
    LQA_EQ_COEFF_ONE = 3'h0,
    LQA_DIGITAL_GAIN = 3'h1,
    LQA_BASELINE_WANDER = 3'h2,
    LQA_FREQ_OFFSET = 3'h3,
    LQA_FREQ_CONTROL = 3'h4,
    LQA_VARIANCE = 3'h5
  } lqa_metric_t;

  // Bus phase, one-hot
  typedef enum logic [1:0] {
    LQA_IDLE = 2'h1,
    LQA_ACCESS = 2'h2
  } lqa_phase_t;

endpackage

/* sim/lqa_top_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lqa_top_tb_top;
  import lqa_pkg::*;
  // ********
  // Signals
  // ********
  localparam logic [9:0] A_DATA = 10'(LQ_DATA_IDX * IDX_TO_BYTE);
  localparam logic [9:0] A_PWR = 10'(POWER_CTRL_IDX * IDX_TO_BYTE);
  localparam logic [9:0] A_BAD = 10'h3FC;
  localparam logic [95:0] LIVE = 96'hB565_B464_B363_B262_B161_B060;
  logic clock, rst_n, psel, penable, pwrite, pready, pslverr, power_down, err;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic [95:0] live_params, limit_table, exp_tab;
  logic [7:0] b;
  int mismatches, n_checks;

  lqa_top u_lqa_top (
    .clock(clock),
    .rst_n(rst_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .live_params(live_params),
    .limit_table(limit_table),
    .power_down(power_down)
  );

  // Free-running 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ********
  // Tasks
  // ********
  task tally_and_finish;
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task chk(input logic [95:0] got, input logic [95:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // Data word layout as software sees it
  function automatic logic [31:0] word(logic lv, logic cm, logic [2:0] m, logic h, logic [7:0] d);
    return {18'h0, lv, cm, m, h, d};
  endfunction

  // One APB transfer; entered just after a rising edge, waits on pready with a bound
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge clock);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: no ready", $time);
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // Store attempt; ok says whether the device should take it
  task commit(input int s, input logic [7:0] d, input logic ok);
    apb(1'b1, A_DATA, word(1'b0, 1'b1, 3'(s / 2), 1'(s % 2), d), 4'h3);
    if (ok) begin
      exp_tab[s*8 +: 8] = d;
    end
    chk(limit_table, exp_tab);
    apb(1'b0, A_DATA, 32'h0, 4'h0);
    chk(rd, word(1'b0, 1'b0, 3'(s / 2), 1'(s % 2), exp_tab[s*8 +: 8]));
  endtask

  // ********
  // Sequence
  // ********
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
    live_params = '0;
    exp_tab = {NUM_SLOTS{LIMIT_SLOT_RESET}};
    mismatches = 0;
    n_checks = 0;
    rst_n = 1'b0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    // Quiet state after reset
    chk(limit_table, exp_tab);
    chk(power_down, 1'b0);
    apb(1'b0, A_DATA, 32'h0, 4'h0);
    chk(rd, 32'h0);
    chk(err, 1'b0);
    // Control lane only: byte field still holds its reset value
    apb(1'b1, A_DATA, word(1'b0, 1'b1, 3'h1, 1'b0, 8'h00), 4'h2);
    exp_tab[23:16] = LIMIT_BYTE_RESET;
    chk(limit_table, exp_tab);
    // Reserved and strobe bits written high never read back
    apb(1'b1, A_DATA, 32'h0000_D05A, 4'h3);
    exp_tab[7:0] = 8'h5A;
    chk(limit_table, exp_tab);
    apb(1'b0, A_DATA, 32'h0, 4'h0);
    chk(rd, 32'h0000_005A);
    // Every metric and both limits, variance included
    for (int s = 0; s < 12; s++) begin
      commit(s, 8'(8'hC0 + s), 1'b1);
    end
    // Select change without strobe only moves the read view
    apb(1'b1, A_DATA, word(1'b0, 1'b0, 3'h2, 1'b1, 8'hFF), 4'h3);
    chk(limit_table, exp_tab);
    apb(1'b0, A_DATA, 32'h0, 4'h0);
    chk(rd, word(1'b0, 1'b0, 3'h2, 1'b1, 8'hC5));
    // Unused metric code stores nothing and reads a zero byte
    apb(1'b1, A_DATA, word(1'b0, 1'b1, 3'h7, 1'b1, 8'h77), 4'h3);
    chk(limit_table, exp_tab);
    apb(1'b0, A_DATA, 32'h0, 4'h0);
    chk(rd, word(1'b0, 1'b0, 3'h7, 1'b1, 8'h00));
    // Snapshot each metric, then disturb the live input
    for (int s = 0; s < 7; s++) begin
      live_params <= LIVE;
      apb(1'b1, A_DATA, word(1'b1, 1'b1, 3'(s > 5 ? 5 : s), s == 6, 8'hEE), 4'h3);
      chk(limit_table, exp_tab);
      live_params <= ~LIVE;
      apb(1'b0, A_DATA, 32'h0, 4'h0);
      b = s == 6 ? 8'hB5 : 8'(8'h60 + (s > 5 ? 5 : s));
      chk(rd, word(1'b1, 1'b0, 3'(s > 5 ? 5 : s), s == 6, b));
    end
    apb(1'b1, A_DATA, word(1'b0, 1'b0, 3'h0, 1'b0, 8'h00), 4'h2);
    apb(1'b0, A_DATA, 32'h0, 4'h0);
    chk(rd, word(1'b0, 1'b0, 3'h0, 1'b0, 8'hC0));
    // Stores refused while powered down, accepted after power-up
    apb(1'b1, A_PWR, 32'h1, 4'h1);
    chk(power_down, 1'b1);
    commit(3, 8'h99, 1'b0);
    apb(1'b1, A_PWR, 32'h0, 4'h1);
    commit(3, 8'h99, 1'b1);
    // Unmapped place: error flag, no side effect, zero data
    apb(1'b1, A_BAD, 32'hFFFF_FFFF, 4'hF);
    chk(err, 1'b1);
    chk(limit_table, exp_tab);
    apb(1'b0, A_BAD, 32'h0, 4'h0);
    chk({err, rd}, {1'b1, 32'h0});
    tally_and_finish();
  end
endmodule
`default_nettype wire
